// *** prom_programmer.sv ***
// Purpose: host that reads and field-programs a 512x4 fuse prom
// Assumes: supply and pulse levels are switched by external drivers
// Notes: one bit programmed per sequence, retried up to the total pulse budget
`timescale 1ns/10ps
module prom_programmer
  import prom_prog_pkg::*;
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic read_req_in,
  input wire logic prog_req_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] pattern_in,
  input wire logic [DATA_W-1:0] prom_data_in,
  output logic busy_out,
  output logic done_out,
  output logic reject_out,
  output logic [DATA_W-1:0] read_data_out,
  output logic [ADDR_W-1:0] prom_addr_out,
  output logic prom_cs_out,
  output logic programming_supply_level_out,
  output logic [DATA_W-1:0] output_program_pulse_level_out,
  output logic [DATA_W-1:0] prom_out_oe_out
);
  typedef enum {IDLE, READ_WAIT, SETUP, RAMP_UP, PRE_DELAY, PULSE, POST_DELAY,
    RAMP_DOWN, VERIFY_WAIT, VERIFY, FINISH} state_t;
  state_t state, next_state;
  logic [DATA_W-1:0] target, next_target;
  logic [1:0] bit_idx, next_bit_idx;
  logic [3:0] pulses, next_pulses;
  logic [DATA_W-1:0] rdata, next_rdata;
  logic next_busy, next_done, next_reject, next_cs, next_supply;
  logic [DATA_W-1:0] next_pulse;
  logic [ADDR_W-1:0] next_addr;
  logic load;
  logic [CNT_W-1:0] load_val;
  logic tmr_done;
  prom_wait_timer prom_wait_timer_inst (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .load_in(load),
    .count_in(load_val),
    .done_out(tmr_done)
  );
  // ---------------------------------------------
  // sequencer; bits still wanted low are target & data read
  // ---------------------------------------------
  always_comb
  begin
    next_state = state;
    next_target = target;
    next_bit_idx = bit_idx;
    next_pulses = pulses;
    next_rdata = rdata;
    next_busy = busy_out;
    next_done = 1'b0;
    next_reject = reject_out;
    next_cs = prom_cs_out;
    next_supply = programming_supply_level_out;
    next_pulse = '0;
    next_addr = prom_addr_out;
    load = 1'b0;
    load_val = '0;
    case (state)
      IDLE:
      begin
        next_cs = 1'b1;
        if (read_req_in)
        begin
          next_addr = addr_in;
          next_cs = 1'b0;
          next_busy = 1'b1;
          load = 1'b1;
          load_val = CNT_W'(ACCESS_CYC);
          next_state = READ_WAIT;
        end
        else if (prog_req_in)
        begin
          next_addr = addr_in;
          next_target = ~pattern_in; // bits to blow
          next_reject = 1'b0;
          next_busy = 1'b1;
          next_pulses = '0;
          next_state = VERIFY_WAIT; // check first: intact bits may need nothing
          next_cs = 1'b0;
          load = 1'b1;
          load_val = CNT_W'(ACCESS_CYC);
        end
      end
      READ_WAIT:
        if (tmr_done)
        begin
          next_rdata = prom_data_in;
          next_cs = 1'b1;
          next_busy = 1'b0;
          next_done = 1'b1;
          next_state = IDLE;
        end
      SETUP:
      begin
        next_cs = 1'b1;
        next_supply = 1'b1; // outputs already released
        load = 1'b1;
        load_val = CNT_W'(RAMP_CYC);
        next_state = RAMP_UP;
      end
      RAMP_UP:
        if (tmr_done)
        begin
          load = 1'b1;
          load_val = CNT_W'(DELAY_CYC);
          next_state = PRE_DELAY;
        end
      PRE_DELAY:
        if (tmr_done)
        begin
          load = 1'b1;
          load_val = CNT_W'(PULSE_CYC);
          next_pulse[bit_idx] = 1'b1;
          next_state = PULSE;
        end
      PULSE:
      begin
        next_pulse[bit_idx] = 1'b1;
        if (tmr_done)
        begin
          next_pulse = '0;
          next_pulses = pulses + 4'h1;
          load = 1'b1;
          load_val = CNT_W'(DELAY_CYC);
          next_state = POST_DELAY; // one bit per pulse
        end
      end
      POST_DELAY:
        if (tmr_done)
        begin
          next_supply = 1'b0;
          load = 1'b1;
          load_val = CNT_W'(RAMP_CYC);
          next_state = RAMP_DOWN;
        end
      RAMP_DOWN:
        if (tmr_done)
        begin
          next_cs = 1'b0;
          load = 1'b1;
          load_val = CNT_W'(ACCESS_CYC);
          next_state = VERIFY_WAIT;
        end
      VERIFY_WAIT:
        if (tmr_done)
        begin
          next_rdata = prom_data_in;
          next_state = VERIFY;
        end
      VERIFY:
      begin
        if ((target & rdata) == '0)
        begin
          next_cs = 1'b1; // all bits to blow read low
          next_state = FINISH;
        end
        else if (target[bit_idx] && rdata[bit_idx] && pulses >= PULSE_NUM)
        begin
          next_reject = 1'b1;
          next_cs = 1'b1;
          next_state = FINISH;
        end
        else if (target[bit_idx] && rdata[bit_idx])
        begin
          next_state = SETUP; // retry same bit
        end
        else
        begin
          next_bit_idx = bit_idx + 2'h1; // next bit
          next_pulses = '0;
          if (target[bit_idx + 2'h1] && rdata[bit_idx + 2'h1])
          begin
            next_state = SETUP;
          end
        end
      end
      FINISH:
      begin
        next_busy = 1'b0;
        next_done = 1'b1;
        next_bit_idx = '0;
        next_state = IDLE;
      end
      default:
        next_state = IDLE;
    endcase
  end
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      state <= IDLE;
      target <= '0;
      bit_idx <= '0;
      pulses <= '0;
      rdata <= ONES;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      reject_out <= 1'b0;
      prom_cs_out <= 1'b1;
      programming_supply_level_out <= 1'b0;
      output_program_pulse_level_out <= '0;
      prom_out_oe_out <= '0;
      prom_addr_out <= '0;
      read_data_out <= ONES;
    end
    else
    begin
      state <= next_state;
      target <= next_target;
      bit_idx <= next_bit_idx;
      pulses <= next_pulses;
      rdata <= next_rdata;
      busy_out <= next_busy;
      done_out <= next_done;
      reject_out <= next_reject;
      prom_cs_out <= next_cs;
      programming_supply_level_out <= next_supply;
      output_program_pulse_level_out <= next_pulse;
      prom_out_oe_out <= next_pulse; // driven only while pulsing, else open
      prom_addr_out <= next_addr;
      read_data_out <= next_rdata;
    end
  end
  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  a_cs_high_supply: assert property (@(posedge clk_in) disable iff (srst_in)
    programming_supply_level_out |-> prom_cs_out) else $error("cs low at high supply");
  a_pulse_needs_supply: assert property (@(posedge clk_in) disable iff (srst_in)
    (output_program_pulse_level_out != '0) |-> programming_supply_level_out)
    else $error("pulse without supply");
  a_one_bit_pulse: assert property (@(posedge clk_in) disable iff (srst_in)
    $onehot0(output_program_pulse_level_out)) else $error("two bits pulsed");
  a_no_drive_rise: assert property (@(posedge clk_in) disable iff (srst_in)
    $rose(programming_supply_level_out) |-> prom_out_oe_out == '0)
    else $error("outputs driven at supply rise");
  a_addr_stable: assert property (@(posedge clk_in) disable iff (srst_in)
    programming_supply_level_out |-> $stable(prom_addr_out)) else $error("addr moved");
  a_delay_before: assert property (@(posedge clk_in) disable iff (srst_in)
    $rose(programming_supply_level_out) |-> output_program_pulse_level_out == '0 [*8])
    else $error("pulse too soon");
  a_delay_after: assert property (@(posedge clk_in) disable iff (srst_in)
    $fell(output_program_pulse_level_out != '0) |-> programming_supply_level_out [*8])
    else $error("supply dropped early");
  a_reject_cause: assert property (@(posedge clk_in) disable iff (srst_in)
    $rose(reject_out) |-> $past(pulses) >= PULSE_NUM) else $error("early reject");
  a_read_cs: assert property (@(posedge clk_in) disable iff (srst_in)
    (state == VERIFY_WAIT) |-> !prom_cs_out && !programming_supply_level_out)
    else $error("verify not enabled");
  // cycles at raised supply since it rose or since the last pulse ended;
  // an eight-cycle window alone would miss a skipped delay state
  logic [CNT_W-1:0] quiet;
  logic [CNT_W-1:0] next_quiet;
  always_comb
  begin
    next_quiet = quiet;
    if (!programming_supply_level_out || (output_program_pulse_level_out != '0))
    begin
      next_quiet = '0;
    end
    else if (quiet != '1)
    begin
      next_quiet = quiet + CNT_W'(1); // saturates, no wrap
    end
  end
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      quiet <= '0;
    end
    else
    begin
      quiet <= next_quiet;
    end
  end
  a_ramp_then_delay: assert property (@(posedge clk_in) disable iff (srst_in)
    $rose(output_program_pulse_level_out != '0) |-> quiet >= RAMP_CYC + DELAY_CYC)
    else $error("pulse before ramp and delay");
  a_delay_before_drop: assert property (@(posedge clk_in) disable iff (srst_in)
    $fell(programming_supply_level_out) && !$past(srst_in) |-> quiet >= DELAY_CYC)
    else $error("supply dropped before delay");
endmodule // prom_programmer

// *** prom_prog_pkg.sv ***
// Purpose: constants for the fuse prom programmer and reader
// Assumes: 40 MHz clock, pins synchronous to clk_in
// Notes: analogue levels are commanded by digital select lines
package prom_prog_pkg;
  localparam int unsigned CLK_MHZ = 40;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 4;
  // times in ns
  localparam int unsigned SUPPLY_RAMP_TIME_NS = 10_000;
  localparam int unsigned PROGRAM_DELAY_NS = 10_000;
  localparam int unsigned PROGRAM_PULSE_WIDTH_NS = 100_000;
  localparam int unsigned TOTAL_PULSE_NS = 1_000_000;
  localparam int unsigned READ_ACCESS_NS = 70;
  // cycle counts; least times round up
  localparam int unsigned RAMP_CYC = (SUPPLY_RAMP_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned DELAY_CYC = (PROGRAM_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PULSE_CYC = (PROGRAM_PULSE_WIDTH_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned ACCESS_CYC = (READ_ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned MAX_PULSES = TOTAL_PULSE_NS / PROGRAM_PULSE_WIDTH_NS;
  localparam int CNT_W = 16;
  localparam logic [3:0] PULSE_NUM = 4'hA;
  localparam logic [3:0] ONES = 4'hF;
endpackage

// *** prom_wait_timer.sv ***
// Purpose: loadable down counter giving a done pulse
// Assumes: load wins over counting
// Notes: done is one cycle when the count reaches zero
`timescale 1ns/10ps
module prom_wait_timer
  import prom_prog_pkg::*;
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic load_in,
  input wire logic [CNT_W-1:0] count_in,
  output logic done_out
);
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic next_done;
  // ---------------------------------------------
  // countdown
  // ---------------------------------------------
  always_comb
  begin
    next_count = count;
    next_done = 1'b0;
    if (load_in)
    begin
      next_count = count_in;
    end
    else if (count != '0)
    begin
      next_count = count - 1'b1;
      next_done = (count == 16'h0001);
    end
  end
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      count <= '0;
      done_out <= 1'b0;
    end
    else
    begin
      count <= next_count;
      done_out <= next_done;
    end
  end
endmodule // prom_wait_timer

// *** prom_fuse_model.sv ***
// Purpose: behavioural 512x4 fuse prom seen by the programmer
// Assumes: a fuse opens after need_in pulses at raised supply; 4'hF never opens
// Notes: a deselected output shows the inverse of its last value
`timescale 1ns/10ps
module prom_fuse_model
  import prom_prog_pkg::*;
(
  input wire logic clk_in,
  input wire logic clear_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic prom_cs_n_in,
  input wire logic supply_in,
  input wire logic [DATA_W-1:0] pulse_in,
  input wire logic [3:0] need_in,
  output logic [DATA_W-1:0] data_out
);
  logic [DATA_W-1:0] mem [0:511];
  logic [3:0] hits [0:DATA_W-1];
  logic [DATA_W-1:0] pulse_q;
  logic [DATA_W-1:0] last;
  // -------------------------------------------------
  // fuse array
  // -------------------------------------------------
  // blank parts hold all ones
  initial
  begin
    for (int i = 0; i < 512; i++) mem[i] = ONES;
    for (int b = 0; b < DATA_W; b++) hits[b] = 4'h0;
    pulse_q = 4'h0;
    last = 4'h0;
  end
  // a pulse counts only with cs high and supply raised
  always @(posedge clk_in)
  begin
    pulse_q <= pulse_in;
    if (!prom_cs_n_in) last <= data_out;
    for (int b = 0; b < DATA_W; b++)
    begin
      if (clear_in) hits[b] <= 4'h0;
      else if (supply_in && prom_cs_n_in && pulse_in[b] && !pulse_q[b])
      begin
        hits[b] <= hits[b] + 4'h1;
        if (need_in != 4'hF && hits[b] + 4'h1 >= need_in) mem[addr_in][b] <= 1'b0;
      end
    end
  end
  // deselected pins float; show a changing value, not the old word
  always_comb data_out = !prom_cs_n_in ? mem[addr_in] : ~last;
endmodule // prom_fuse_model

// *** fuse_prom_program_verify_test.sv ***
// Purpose: self-checking bench for the prom programmer
// Assumes: fuse model on the far side
// Notes: pulse count checked by counting rising pulse edges
`timescale 1ns/10ps
module fuse_prom_program_verify_test;
  import prom_prog_pkg::*;
  logic clk_in = 0, srst_in = 1, read_req = 0, prog_req = 0, clear = 0;
  logic [ADDR_W-1:0] addr = 9'h000;
  logic [DATA_W-1:0] pattern = 4'h0, model_q, pin, rd, pulse, oe, pulse_q = 4'h0;
  logic [ADDR_W-1:0] paddr;
  logic [3:0] need = 4'h1;
  logic busy, done, reject, cs, supply;
  int bad_count = 0, tests_run = 0, pulses = 0, viol = 0;
  always #12.5 clk_in = ~clk_in;
  // pin level: our driver wins where its enable is up
  assign pin = (oe & pulse) | (~oe & model_q);
  prom_programmer prom_programmer_inst (.clk_in(clk_in), .srst_in(srst_in),
    .read_req_in(read_req), .prog_req_in(prog_req), .addr_in(addr), .pattern_in(pattern),
    .prom_data_in(pin), .busy_out(busy), .done_out(done), .reject_out(reject),
    .read_data_out(rd), .prom_addr_out(paddr), .prom_cs_out(cs),
    .programming_supply_level_out(supply), .output_program_pulse_level_out(pulse),
    .prom_out_oe_out(oe));
  prom_fuse_model prom_fuse_model_inst (.clk_in(clk_in), .clear_in(clear), .addr_in(paddr),
    .prom_cs_n_in(cs), .supply_in(supply), .pulse_in(pulse), .need_in(need),
    .data_out(model_q));
  // sequence monitor: pulses counted, illegal pin combinations noted
  always @(posedge clk_in)
  begin
    pulse_q <= pulse;
    if (clear)
    begin
      pulses <= 0;
      viol <= 0;
    end
    else
    begin
      if (|(pulse & ~pulse_q)) pulses <= pulses + 1;
      if ((supply && !cs) || (|pulse && !supply) || (oe != pulse)) viol <= viol + 1;
    end
  end
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (exp !== got)
    begin
      bad_count++;
      $display("unexpected %s: expected %0h seen %0h", name, exp, got);
    end
  endtask
  // one request, held a cycle, then a bounded wait for done
  task automatic op(input logic rq, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] p);
    @(posedge clk_in);
    read_req <= rq;
    prog_req <= !rq;
    addr <= a;
    pattern <= p;
    @(posedge clk_in);
    read_req <= 0;
    prog_req <= 0;
    #1;
    check("busy", 1, busy);
    for (int i = 0; i < 70000; i++)
    begin
      @(posedge clk_in);
      #1;
      if (done === 1'b1) break;
    end
    check("done", 1, done);
    check("busy", 0, busy);
    check("addr", a, paddr);
  endtask
  task automatic prog(input logic [3:0] n, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] p);
    @(posedge clk_in);
    clear <= 1;
    need <= n;
    @(posedge clk_in);
    clear <= 0;
    op(0, a, p);
    #1;
    check("viol", 0, viol);
  endtask
  task automatic t_blank;
    op(1, 9'h1FF, 4'h0);
    check("blank", 4'hF, rd);
    check("cs", 1, cs);
  endtask
  task automatic t_two_bits;
    prog(4'h1, 9'h0A5, 4'h5);
    check("pulses", 2, pulses);
    check("reject", 0, reject);
    op(1, 9'h0A5, 4'h0);
    check("word", 4'h5, rd);
  endtask
  task automatic t_retry;
    prog(4'h3, 9'h003, 4'hE);
    check("pulses", 3, pulses);
    check("reject", 0, reject);
    op(1, 9'h003, 4'h0);
    check("word", 4'hE, rd);
  endtask
  task automatic t_reject;
    prog(4'hF, 9'h004, 4'h7);
    check("pulses", MAX_PULSES, pulses);
    check("reject", 1, reject);
  endtask
  task automatic t_permanent;
    prog(4'h1, 9'h0A5, 4'hF);
    check("pulses", 0, pulses);
    op(1, 9'h0A5, 4'h0);
    check("word", 4'h5, rd);
  endtask
  // reset while the supply is raised must drop it and release the pins
  task automatic t_abort;
    @(posedge clk_in);
    prog_req <= 1;
    addr <= 9'h1F0;
    pattern <= 4'hE;
    @(posedge clk_in);
    prog_req <= 0;
    repeat (500) @(posedge clk_in);
    #1;
    check("abort supply up", 1, supply);
    check("abort cs", 1, cs);
    @(posedge clk_in);
    srst_in <= 1;
    @(posedge clk_in);
    srst_in <= 0;
    #1;
    check("abort supply", 0, supply);
    check("abort cs", 1, cs);
    check("abort busy", 0, busy);
    check("abort oe", 0, oe);
    op(1, 9'h1F0, 4'h0);
    check("aborted word", 4'hF, rd);
    check("viol", 0, viol);
  endtask
  task automatic results;
    $display("tests_run %0d bad_count %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // watchdog: the run needs about 85000 cycles
  initial
  begin
    #(98000 * 25);
    bad_count++;
    results();
  end
  initial
  begin
    repeat (12) @(posedge clk_in);
    srst_in <= 0;
    #1;
    check("reset cs", 1, cs);
    check("reset supply", 0, supply);
    t_blank();
    t_two_bits();
    t_retry();
    t_reject();
    t_permanent();
    t_abort();
    results();
  end
endmodule // fuse_prom_program_verify_test
